// >>> shared/rep_params.svh
/*
  Constants of the (1,7) encoder/decoder pin data path: register offsets,
  config width, reset value, phase and bit-count limits and the zero code word.
  Assumes inclusion by bare name from the package and from the design.
*/
// What this block does
// - Coded write data leaves serially on the code output, MSB first.
// - A setting picks single-ended TTL or differential ECL code output.
// - In TTL form a setting inverts the code output.
// - In TTL form a setting floats the code output.
// - A setting bypasses precompensation; early and late then stay low.
// - A setting bypasses the encoder; the test pattern goes straight out.
// - The complementary output is the inverse, active only in ECL form.
// - In TTL form the complementary output is always floating.
// - Early flag is high when the current transition needs early shift.
// - Late flag is high when the current transition needs late shift.
// - The read/reference clock runs out continuously in every mode.
// - External mode samples both NRZ bits on the write clock rise.
// - Reads drive decoded NRZ data, captured on reference clock rise.
// - NRZ is two bidirectional bits, pin zero LSB, pin one MSB.
// - Three code bits per two-bit symbol; reference clock is code/3.
// - Read gate low inhibits reading and resets the decoder.
// - Write gate low inhibits writing and resets the encoder.
// - Read data sampled on code clock fall; writes shift on its rise.
// - Erase in write mode holds the code output at its inactive level.
`ifndef REP_PARAMS_SVH
`define REP_PARAMS_SVH
`define REP_ADDR_W      4
`define REP_OFS_CFG     4'h0
`define REP_OFS_STAT    4'h4
`define REP_CFG_W       6
`define REP_CFG_RST     6'h00
`define REP_PH_LAST     3'h5
`define REP_PH_FALL     3'h2
`define REP_BIT_LAST    2'h2
`define REP_WORD_ZERO   3'h0
`endif

// >>> shared/rep_pkg.sv
/*
  Types of the (1,7) encoder/decoder pin data path.
  Assumes rep_params.svh on the include path.
*/
`include "rep_params.svh"
package rep_pkg;
  // Configuration word as software writes it, bit 5 first.
  typedef struct packed {
    logic ext_wclk;
    logic enc_bypass;
    logic pc_bypass;
    logic float_out;
    logic invert;
    logic ecl;
  } rep_cfg_t;
  // Operating mode, one-hot.
  typedef enum logic [2:0] {
    REP_IDLE  = 3'b001,
    REP_READ  = 3'b010,
    REP_WRITE = 3'b100
  } rep_mode_t;
endpackage

// >>> rtl/rep_datapath.sv
/*
  Pin-level data path of a 2/3 (1,7) run-length-limited encoder/decoder.
  Assumes pin inputs are asynchronous to ref_clk_i and that the code
  clock is well below a quarter of ref_clk_i so its edges can be found.
*/
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "rep_params.svh"
module rep_datapath
  import rep_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [`REP_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  input  wire logic                  sync_code_clock_i,
  input  wire logic                  sync_code_data_i,
  input  wire logic                  read_gate_i,
  input  wire logic                  write_gate_i,
  input  wire logic                  ext_write_clock_i,
  input  wire logic                  erase_i,
  input  wire logic                  nrz_lsb_in_i,
  input  wire logic                  nrz_msb_in_i,
  output logic                       nrz_lsb_out_o,
  output logic                       nrz_msb_out_o,
  output logic                       nrz_lsb_oe_o,
  output logic                       nrz_msb_oe_o,
  output logic                       read_reference_clock_o,
  output logic                       code_o,
  output logic                       code_oe_o,
  output logic                       code_n_o,
  output logic                       code_n_oe_o,
  output logic                       early_o,
  output logic                       late_o
);
  // ------------------------------------------------------------------
  // Code tables
  // ------------------------------------------------------------------
  // Basic 2-to-3 code word of a symbol.
  function automatic logic [2:0] enc_word(input logic [1:0] s);
    unique case (s)
      2'h0: enc_word = 3'h5;
      2'h1: enc_word = 3'h4;
      2'h2: enc_word = 3'h1;
      2'h3: enc_word = 3'h2;
    endcase
  endfunction
  // Symbol of a basic code word; illegal words read as zero.
  function automatic logic [1:0] dec_word(input logic [2:0] w);
    case (w)
      3'h4:    dec_word = 2'h1;
      3'h1:    dec_word = 2'h2;
      3'h2:    dec_word = 2'h3;
      default: dec_word = 2'h0;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers and edge finding
  // ------------------------------------------------------------------
  logic [7:0] pin_a, pin_b, pin_c;
  wire  [7:0] pin_raw = {nrz_msb_in_i, nrz_lsb_in_i, erase_i,
                         ext_write_clock_i, write_gate_i, read_gate_i,
                         sync_code_data_i, sync_code_clock_i};
  // Two flops per pin, a third only for edge detection.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_a <= 8'h00;
      pin_b <= 8'h00;
      pin_c <= 8'h00;
    end else begin
      pin_a <= pin_raw;
      pin_b <= pin_a;
      pin_c <= pin_b;
    end
  end
  wire       cc_rise  = pin_b[0] & ~pin_c[0];
  wire       cc_fall  = ~pin_b[0] & pin_c[0];
  wire       half_tk  = cc_rise | cc_fall;
  wire       sdata    = pin_b[1];
  wire       rgate    = pin_b[2];
  wire       wgate    = pin_b[3];
  wire       wclk_up  = pin_b[4] & ~pin_c[4];
  wire       erase_s  = pin_b[5];
  wire [1:0] nrz_s    = pin_b[7:6];

  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  rep_cfg_t    cfg;
  rep_mode_t   mode;
  logic [31:0] rdata;
  logic [1:0]  sym, nrz_out;
  wire sel_cfg  = reg_addr_i == `REP_OFS_CFG;
  wire sel_stat = reg_addr_i == `REP_OFS_STAT;
  wire [31:0] stat_word = {25'h0, mode, nrz_out, sym};
  wire [31:0] next_rdata = !reg_rd_i ? 32'h0 :
                           sel_cfg   ? {26'h0, cfg} :
                           sel_stat  ? stat_word : 32'h0;
  // Configuration write and read data one cycle after the strobe.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg   <= `REP_CFG_RST;
      rdata <= 32'h0;
    end else begin
      if (reg_wr_i && sel_cfg) cfg <= reg_wdata_i[`REP_CFG_W-1:0];
      rdata <= next_rdata;
    end
  end
  assign reg_rdata_o = rdata;

  // ------------------------------------------------------------------
  // Mode and reference clock
  // ------------------------------------------------------------------
  // Mode follows the gates; read wins when both are high, so that the
  // decoder owns the NRZ pins then and the two modes never overlap.
  rep_mode_t next_mode;
  assign next_mode = rgate ? REP_READ :
                     wgate ? REP_WRITE :
                     REP_IDLE;
  wire rd_on = mode == REP_READ;
  wire wr_on = mode == REP_WRITE;

  // Six code half-periods make one reference period, in every mode.
  logic [2:0] ph;
  logic       rr;
  wire [2:0] next_ph = (ph == `REP_PH_LAST) ? 3'h0 : ph + 3'h1;
  wire       rr_up   = half_tk && ph == `REP_PH_LAST;
  wire       rr_dn   = half_tk && ph == `REP_PH_FALL;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= REP_IDLE;
      ph   <= 3'h0;
      rr   <= 1'b0;
    end else begin
      mode <= next_mode;
      if (half_tk) ph <= next_ph;
      if (rr_up) rr <= 1'b1;
      else if (rr_dn) rr <= 1'b0;
    end
  end
  assign read_reference_clock_o = rr;

  // ------------------------------------------------------------------
  // Decoder
  // ------------------------------------------------------------------
  logic [1:0] dsh, dcnt, dp, dres;
  logic       dpv;
  wire  [2:0] dw      = {dsh, sdata};
  wire        dw_zero = dw == `REP_WORD_ZERO;
  wire        dw_done = rd_on && cc_fall && dcnt == `REP_BIT_LAST;
  // Shift code bits in on the falling edge; the all-zero word undoes
  // the substituted pair.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dsh <= 2'h0; dcnt <= 2'h0; dp <= 2'h0; dpv <= 1'b0; dres <= 2'h0;
    end else if (!rd_on) begin
      dsh <= 2'h0; dcnt <= 2'h0; dpv <= 1'b0;
    end else if (cc_fall) begin
      dsh  <= dw[1:0];
      dcnt <= dw_done ? 2'h0 : dcnt + 2'h1;
      if (dw_done) begin
        dpv <= 1'b1;
        dp  <= (dpv && dw_zero) ? {1'b0, dp[0]} : dec_word(dw);
        if (dpv) dres <= dw_zero ? {dp[1], 1'b0} : dp;
      end
    end
  end
  // Read data change at the reference fall, stable for its rise.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) nrz_out <= 2'h0;
    else if (rr_dn) nrz_out <= rd_on ? dres : 2'h0;
  end
  assign nrz_lsb_out_o = nrz_out[0];
  assign nrz_msb_out_o = nrz_out[1];
  assign nrz_lsb_oe_o  = rd_on;
  assign nrz_msb_oe_o  = rd_on;

  // ------------------------------------------------------------------
  // Encoder
  // ------------------------------------------------------------------
  logic [1:0] ep;
  logic       epv, fz;
  logic [2:0] whold, sh;
  logic [1:0] bcnt;
  wire sym_tk = wr_on && (cfg.ext_wclk ? wclk_up : rr_up);
  wire sub    = !fz && !ep[0] && !sym[1];
  wire [2:0] next_word = fz  ? `REP_WORD_ZERO :
                         sub ? enc_word({ep[1], sym[0]}) : enc_word(ep);
  // Capture the symbol, then code the held one with one of lookahead.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sym <= 2'h0; ep <= 2'h0; epv <= 1'b0; fz <= 1'b0;
      whold <= `REP_WORD_ZERO;
    end else if (!wr_on) begin
      epv <= 1'b0; fz <= 1'b0; whold <= `REP_WORD_ZERO;
    end else begin
      if (sym_tk) sym <= nrz_s;
      if (cc_rise && bcnt == 2'h0) begin
        ep  <= sym;
        epv <= 1'b1;
        if (epv) whold <= next_word;
        if (epv) fz <= sub;
      end
    end
  end
  wire sbit = cfg.enc_bypass ? nrz_s[0] :
              (bcnt == 2'h0) ? whold[2] : sh[1];
  logic [4:0] win;
  // Serialise MSB first; the window feeds the pattern check.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh <= 3'h0; bcnt <= 2'h0; win <= 5'h00;
    end else if (!wr_on) begin
      sh <= 3'h0; bcnt <= 2'h0; win <= 5'h00;
    end else if (cc_rise) begin
      sh   <= (bcnt == 2'h0) ? whold : {sh[1:0], 1'b0};
      bcnt <= (bcnt == `REP_BIT_LAST) ? 2'h0 : bcnt + 2'h1;
      win  <= {win[3:0], sbit};
    end
  end

  // ------------------------------------------------------------------
  // Precompensation and output stage
  // ------------------------------------------------------------------
  wire pc_on   = !cfg.pc_bypass && !cfg.enc_bypass;
  wire e_need  = pc_on && win[2] && win[0] && !win[4];
  wire l_need  = pc_on && win[2] && win[4] && !win[0];
  wire inv     = cfg.invert && !cfg.ecl;
  wire quiet   = !wr_on || erase_s;
  wire next_co = quiet ? inv : win[2] ^ inv;
  logic co, ce, cn, cne, ea, la;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      co <= 1'b0; ce <= 1'b0; cn <= 1'b0; cne <= 1'b0;
      ea <= 1'b0; la <= 1'b0;
    end else begin
      co  <= next_co;
      ce  <= cfg.ecl || !cfg.float_out;
      cn  <= ~next_co;
      cne <= cfg.ecl;
      ea  <= e_need && !quiet;
      la  <= l_need && !quiet;
    end
  end
  assign code_o      = co;
  assign code_oe_o   = ce;
  assign code_n_o    = cn;
  assign code_n_oe_o = cne;
  assign early_o     = ea;
  assign late_o      = la;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] hc;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) hc <= 2'h0;
    else if (rr_up || rr_dn) hc <= 2'h0;
    else if (half_tk) hc <= hc + 2'h1;
  end
  sequence s_erase_on; wr_on && erase_s; endsequence
  property p_rr_rate;
    (rr_up || rr_dn) && $past(rr_up || rr_dn) == 1'b0 |-> hc == 2'h2;
  endproperty
  a_rr_rate: assert property (p_rr_rate)
    else $error("reference clock not one third of code clock");
  property p_compl; cne |-> cn == ~co; endproperty
  a_compl: assert property (p_compl)
    else $error("complementary output not inverse");
  property p_ttl_float; !cfg.ecl |=> !cne; endproperty
  a_ttl_float: assert property (p_ttl_float)
    else $error("complementary output driven in TTL form");
  property p_hiz; !cfg.ecl && cfg.float_out |=> !ce; endproperty
  a_hiz: assert property (p_hiz)
    else $error("code output driven while floated");
  property p_nrz_oe; nrz_lsb_oe_o == rd_on && nrz_msb_oe_o == rd_on;
  endproperty
  a_nrz_oe: assert property (p_nrz_oe)
    else $error("NRZ pins driven outside read");
  property p_erase; s_erase_on ##1 s_erase_on |=> co == inv; endproperty
  a_erase: assert property (p_erase)
    else $error("code output moves during erase");
  property p_pc_off; cfg.pc_bypass |=> !ea && !la; endproperty
  a_pc_off: assert property (p_pc_off)
    else $error("precompensation flag while bypassed");
  property p_early; !quiet && e_need |=> ea; endproperty
  a_early: assert property (p_early)
    else $error("early flag missing");
  property p_late; !quiet && l_need |=> la && !ea; endproperty
  a_late: assert property (p_late)
    else $error("late flag missing");
  property p_dec_rst; !rd_on |=> dcnt == 2'h0 && !dpv; endproperty
  a_dec_rst: assert property (p_dec_rst)
    else $error("decoder not held in reset");
  property p_ext_smp;
    wr_on && cfg.ext_wclk && wclk_up |=> sym == $past(nrz_s);
  endproperty
  a_ext_smp: assert property (p_ext_smp)
    else $error("NRZ not sampled on write clock rise");
endmodule
`default_nettype wire

// >>> test/rep_channel_model.sv
/*
  Behavioural model of the read channel and the controller's clock echo.
  Assumes the bench sets the 3-bit code pattern and wires the echo.
*/
`timescale 1ns/1ps
`default_nettype none
module rep_channel_model (
  input  wire logic       read_reference_clock_i,
  input  wire logic [2:0] pattern_i,
  output logic            code_clk_o,
  output logic            code_data_o,
  output logic            wclk_o
);
  logic [1:0] idx;

  // The code clock runs free, since the reference clock needs it always.
  initial begin
    code_clk_o = 1'b0;
    code_data_o = 1'b0;
    idx = 2'h0;
  end
  always #80 code_clk_o = ~code_clk_o;

  // Data moves on the rise so it is settled at the falling sample.
  always @(posedge code_clk_o) begin
    code_data_o <= pattern_i[2'h2 - idx];
    idx <= (idx == 2'h2) ? 2'h0 : idx + 2'h1;
  end

  // The controller returns the reference clock as its write clock.
  assign wclk_o = read_reference_clock_i;
endmodule
`default_nettype wire

// >>> test/rep_datapath_tb.sv
/*
  Self-checking bench of the encoder/decoder pin data path.
  Assumes rep_pkg, the design and the channel model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module rep_datapath_tb
  import rep_pkg::*;
;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        rg = 1'b0, wg = 1'b0, erase = 1'b0;
  logic        lsb_drv = 1'b0, msb_drv = 1'b0;
  logic [2:0]  pattern = 3'h0;
  wire  logic [31:0] rdata;
  wire  logic  scc, scd, wclk, rr, code, code_oe, code_n, code_n_oe;
  wire  logic  early, late, lsb_o, msb_o, lsb_oe, msb_oe, lsb_w, msb_w;
  int          err_count = 0, checked = 0;
  int          edges, early_n, late_n, rr_n;
  logic [31:0] v;

  always #5 ref_clk_i = ~ref_clk_i;
  // The pin level is the design's when it drives, else the controller's.
  assign lsb_w = lsb_oe ? lsb_o : lsb_drv;
  assign msb_w = msb_oe ? msb_o : msb_drv;

  rep_channel_model i_rep_channel_model (.read_reference_clock_i(rr), .pattern_i(pattern),
    .code_clk_o(scc), .code_data_o(scd), .wclk_o(wclk));
  rep_datapath i_rep_datapath (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .sync_code_clock_i(scc), .sync_code_data_i(scd), .read_gate_i(rg),
    .write_gate_i(wg), .ext_write_clock_i(wclk), .erase_i(erase),
    .nrz_lsb_in_i(lsb_w), .nrz_msb_in_i(msb_w), .nrz_lsb_out_o(lsb_o),
    .nrz_msb_out_o(msb_o), .nrz_lsb_oe_o(lsb_oe), .nrz_msb_oe_o(msb_oe),
    .read_reference_clock_o(rr), .code_o(code), .code_oe_o(code_oe),
    .code_n_o(code_n), .code_n_oe_o(code_n_oe), .early_o(early),
    .late_o(late));

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe beside address and data.
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Counts code edges, flag cycles and reference clock rises.
  task automatic watch(input int n);
    logic pc, pr;
    pc = code;
    pr = rr;
    edges = 0;
    early_n = 0;
    late_n = 0;
    rr_n = 0;
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
      edges += (code !== pc);
      early_n += (early === 1'b1);
      late_n += (late === 1'b1);
      rr_n += (rr === 1'b1 && pr === 1'b0);
      pc = code;
      pr = rr;
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need about 45 us.
  initial begin
    #300000;
    err_count++;
    results();
  end

  // Main sequence.
  initial begin
    static logic [5:0] cfg [4] = '{6'h02, 6'h06, 6'h01, 6'h05};
    static logic [2:0] exp [4] = '{3'b110, 3'b100, 3'b011, 3'b011};
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    check("code_oe", code_oe, 1'b1);
    check("code_n_oe", code_n_oe, 1'b0);
    check("code idle", code, 1'b0);
    rd_reg(4'h0, v);
    check("cfg reset", v, 32'h0);
    rd_reg(4'h8, v);
    check("unmapped", v, 32'h0);
    rd_reg(4'h4, v);
    check("mode idle", v[6:4], 3'b001);
    watch(480);
    check("rr rises", rr_n >= 9 && rr_n <= 11, 1'b1);
    check("nrz oe idle", {msb_oe, lsb_oe}, 2'h0);
    // Output forms: {code, code_oe, code_n_oe} per setting.
    for (int i = 0; i < 4; i++) begin
      wr_reg(4'h0, {26'h0, cfg[i]});
      check("form", {code, code_oe, code_n_oe}, exp[i]);
      if (code_n_oe === 1'b1) check("code_n", code_n, {31'h0, ~code});
    end
    wr_reg(4'h0, 32'h0);
    check("code_n ttl", code_n_oe, 1'b0);
    // Read: the decoder drives both pins with nonzero data for 010.
    rg <= 1'b1;
    pattern <= 3'b010;
    watch(480);
    check("nrz oe read", {msb_oe, lsb_oe}, 2'h3);
    check("nrz data", msb_o | lsb_o, 1'b1);
    rd_reg(4'h4, v);
    check("mode read", v[6:4], 3'b010);
    rg <= 1'b0;
    watch(8);
    check("nrz release", {msb_oe, lsb_oe}, 2'h0);
    // Write a preamble: NRZ held low, code toggles, precomp fires.
    wg <= 1'b1;
    lsb_drv <= 1'b0;
    msb_drv <= 1'b0;
    watch(960);
    check("code edges", edges > 0, 1'b1);
    check("early seen", early_n > 0, 1'b1);
    check("late seen", late_n > 0, 1'b1);
    check("nrz oe write", {msb_oe, lsb_oe}, 2'h0);
    rd_reg(4'h4, v);
    check("mode write", v[6:4], 3'b100);
    erase <= 1'b1;
    watch(20);
    watch(480);
    check("erase edges", edges, 32'h0);
    check("erase level", code, 1'b0);
    erase <= 1'b0;
    wr_reg(4'h0, 32'h08);
    watch(480);
    check("bypass flags", early_n + late_n, 32'h0);
    check("bypass edges", edges > 0, 1'b1);
    wr_reg(4'h0, 32'h20);
    watch(960);
    check("ext wclk edges", edges > 0, 1'b1);
    wr_reg(4'h0, 32'h10);
    for (int b = 1; b >= 0; b--) begin
      lsb_drv <= b[0];
      watch(100);
      watch(160);
      check("raw level", code, b[0]);
      check("raw steady", edges, 32'h0);
    end
    wg <= 1'b0;
    watch(20);
    rd_reg(4'h4, v);
    check("mode off", v[6:4], 3'b001);
    results();
  end
endmodule
`default_nettype wire
